// file: logic/tws_channel.sv
// One three-wire serial channel with its registers
//
// Behaviour
// - Enabled transmit mode: buffer write starts transfer
// - Buffer byte loaded, shifted out on data out
// - Transmit buffer byte read/write, reset 00h
// - Receive mode: shift register read starts transfer
// - Eight-bit shift register, both directions, readable
// - Receive shifts serial input bits in
// - Clearing enable stops channel, resets logic
// - Disable clears busy flag and shift register
// - Mode bit: receive-only or transmit/receive
// - Receive-only mode holds data out low
// - Busy flag read-only, one while transferring
// - Slave-select use bit gates select input
// - Select input matters only in slave mode
// - Mode register bit or byte writes, reset 00h
// - Order bit picks MSB or LSB first
// - Clock field: divided clock or external clock
`timescale 1ns/1ps
`default_nettype none
module tws_channel
  import tws_pkg::*;
#(
  parameter logic [15:0] BASE_OFFSET = 16'h0000,
  parameter bit HAS_SLAVE_SELECT = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Internal byte bus
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_bit_mask,
  output logic [7:0] bus_rdata,
  output logic bus_hit,
  // Serial pins
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  input wire logic serial_data_in,
  output logic serial_data_out,
  input wire logic slave_select_in_n,
  // Received bytes toward a consumer
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  // Event
  output logic transfer_done_irq
);
  typedef enum logic [2:0] {
    TWS_IDLE = 3'b001,
    TWS_LOW = 3'b010,
    TWS_HIGH = 3'b100
  } tws_state_e;

  tws_state_e state, next_state;
  logic [7:0] mode_ctrl, next_mode_ctrl;
  logic [7:0] clock_ctrl, next_clock_ctrl;
  logic [7:0] transmit_buffer, next_transmit_buffer;
  logic [7:0] shift_register, next_shift_register;
  logic [3:0] bit_count, next_bit_count;
  logic [7:0] div_count, next_div_count;
  logic sclk_out, next_sclk_out;
  logic sdo, next_sdo;
  logic done, next_done;
  logic [7:0] rdata, next_rdata;
  logic hit, next_hit;
  logic oe, next_oe;
  logic sck_s, sdi_s, ssi_s, sck_prev;
  logic enable, txrx, lsb_first, ss_use, busy, slave, ss_ok;
  logic sel_mode, sel_clk, sel_tx, sel_sio;
  logic start, rise, fall;
  logic buf_in_ready, buf_in_valid;

  function automatic logic [7:0] merge_bits(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic [7:0] mask);
    merge_bits = (old_v & ~mask) | (new_v & mask);
  endfunction : merge_bits

  function automatic logic [7:0] half_period(input logic [2:0] sel);
    half_period = 8'h01 << sel;
  endfunction : half_period

  tws_sync u_sync_sck (.ref_clk(ref_clk), .rst(rst), .din(serial_clock_pin_in), .dout(sck_s));
  tws_sync u_sync_sdi (.ref_clk(ref_clk), .rst(rst), .din(serial_data_in), .dout(sdi_s));
  tws_sync u_sync_ssi (.ref_clk(ref_clk), .rst(rst), .din(slave_select_in_n), .dout(ssi_s));

  tws_buf2 #(.WIDTH(8)) u_rx_buf (
    .ref_clk(ref_clk), .rst(rst),
    .in_valid(buf_in_valid), .in_data(shift_register), .in_ready(buf_in_ready),
    .out_valid(rx_valid), .out_data(rx_data), .out_ready(rx_ready)
  );

  assign enable = mode_ctrl[BIT_CHANNEL_ENABLE];
  assign txrx = mode_ctrl[BIT_TXRX_MODE_SEL];
  assign lsb_first = mode_ctrl[BIT_FIRST_BIT_ORDER];
  assign ss_use = HAS_SLAVE_SELECT && mode_ctrl[BIT_SLAVE_SELECT_USE];
  assign busy = (state != TWS_IDLE);
  assign slave = (clock_ctrl[2:0] == CLK_SEL_EXTERNAL);
  assign ss_ok = !(slave && ss_use) || !ssi_s;
  assign sel_mode = (bus_addr == BASE_OFFSET + ADDR_MODE_CTRL_CH0);
  assign sel_clk = (bus_addr == BASE_OFFSET + ADDR_CLOCK_CTRL_CH0);
  assign sel_tx = (bus_addr == BASE_OFFSET + ADDR_TRANSMIT_BUFFER);
  assign sel_sio = (bus_addr == BASE_OFFSET + ADDR_SHIFT_REGISTER);
  assign start = enable && !busy && buf_in_ready &&
    ((txrx && bus_wr && sel_tx) || (!txrx && bus_rd && sel_sio));
  assign rise = slave ? (sck_s && !sck_prev && ss_ok) : (state == TWS_LOW && div_count == 8'h00);
  assign fall = slave ? (!sck_s && sck_prev && ss_ok) : (state == TWS_HIGH && div_count == 8'h00);
  assign buf_in_valid = done;

  // Register file
  always_comb begin
    next_mode_ctrl = mode_ctrl;
    next_clock_ctrl = clock_ctrl;
    next_transmit_buffer = transmit_buffer;
    if (bus_wr && sel_mode) begin
      next_mode_ctrl = merge_bits(mode_ctrl, bus_wdata, bus_bit_mask & 8'hf0);
      if (!HAS_SLAVE_SELECT) begin
        next_mode_ctrl[BIT_SLAVE_SELECT_USE] = 1'b0;
      end
    end
    if (bus_wr && sel_clk) begin
      next_clock_ctrl = merge_bits(clock_ctrl, bus_wdata, bus_bit_mask & 8'h1f);
    end
    if (bus_wr && sel_tx) begin
      next_transmit_buffer = bus_wdata;
    end
    next_oe = next_mode_ctrl[BIT_CHANNEL_ENABLE] &&
      (next_clock_ctrl[2:0] != CLK_SEL_EXTERNAL);
    next_rdata = 8'h00;
    if (sel_mode) begin
      next_rdata = {mode_ctrl[7:1], busy};
    end else if (sel_clk) begin
      next_rdata = clock_ctrl;
    end else if (sel_tx) begin
      next_rdata = transmit_buffer;
    end else if (sel_sio) begin
      next_rdata = shift_register;
    end
    next_hit = bus_rd && (sel_mode || sel_clk || sel_tx || sel_sio);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_ctrl <= MODE_CTRL_RESET;
      clock_ctrl <= CLOCK_CTRL_RESET;
      transmit_buffer <= TRANSMIT_BUFFER_RESET;
      rdata <= 8'h00;
      hit <= 1'b0;
      oe <= 1'b0;
      sck_prev <= 1'b0;
    end else begin
      oe <= next_oe;
      mode_ctrl <= next_mode_ctrl;
      clock_ctrl <= next_clock_ctrl;
      transmit_buffer <= next_transmit_buffer;
      rdata <= next_rdata;
      hit <= next_hit;
      sck_prev <= sck_s;
    end
  end

  // Shift engine
  always_comb begin
    next_state = state;
    next_shift_register = shift_register;
    next_bit_count = bit_count;
    next_div_count = (div_count == 8'h00) ? 8'h00 : div_count - 8'h01;
    next_sclk_out = sclk_out;
    next_sdo = txrx ? sdo : 1'b0;
    next_done = 1'b0;
    if (!enable) begin
      next_state = TWS_IDLE;
      next_shift_register = SHIFT_REGISTER_RESET;
      next_bit_count = 4'h0;
      next_sclk_out = 1'b1;
      next_sdo = 1'b0;
    end else begin
      case (state)
        TWS_IDLE: begin
          next_sclk_out = 1'b1;
          if (start) begin
            next_shift_register = txrx ? (bus_wr ? bus_wdata : transmit_buffer)
                                       : shift_register;
            if (txrx) begin
              next_sdo = lsb_first ? bus_wdata[0] : bus_wdata[7];
            end
            next_bit_count = 4'h0;
            next_div_count = half_period(clock_ctrl[2:0]) - 8'h01;
            next_sclk_out = 1'b0;
            next_state = TWS_LOW;
          end
        end
        TWS_LOW: begin
          if (rise) begin
            next_sclk_out = 1'b1;
            next_div_count = half_period(clock_ctrl[2:0]) - 8'h01;
            next_bit_count = bit_count + 4'h1;
            if (lsb_first) begin
              next_shift_register = {sdi_s, shift_register[7:1]};
            end else begin
              next_shift_register = {shift_register[6:0], sdi_s};
            end
            next_state = TWS_HIGH;
          end
        end
        TWS_HIGH: begin
          if (bit_count == FRAME_BITS) begin
            next_state = TWS_IDLE;
            next_done = 1'b1;
          end else if (fall) begin
            next_sclk_out = 1'b0;
            next_div_count = half_period(clock_ctrl[2:0]) - 8'h01;
            if (txrx) begin
              next_sdo = lsb_first ? shift_register[0] : shift_register[7];
            end
            next_state = TWS_LOW;
          end
        end
        default: begin
          next_state = TWS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= TWS_IDLE;
      shift_register <= SHIFT_REGISTER_RESET;
      bit_count <= 4'h0;
      div_count <= 8'h00;
      sclk_out <= 1'b1;
      sdo <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      shift_register <= next_shift_register;
      bit_count <= next_bit_count;
      div_count <= next_div_count;
      sclk_out <= next_sclk_out;
      sdo <= next_sdo;
      done <= next_done;
    end
  end

  assign bus_rdata = rdata;
  assign bus_hit = hit;
  assign serial_clock_pin_out = sclk_out;
  assign serial_data_out = sdo;
  assign transfer_done_irq = done;
  assign serial_clock_pin_oe = oe;

  sequence s_start_tx;
    start && txrx;
  endsequence

  a_tx_starts_busy: assert property (@(posedge ref_clk) disable iff (rst)
    s_start_tx |=> busy) else $error("transfer did not start");
  a_rx_start_busy: assert property (@(posedge ref_clk) disable iff (rst)
    (start && !txrx) |=> (state == TWS_LOW)) else $error("receive did not start");
  a_disable_clears: assert property (@(posedge ref_clk) disable iff (rst)
    !enable |=> (!busy && shift_register == 8'h00)) else $error("disable left state");
  a_rx_out_low: assert property (@(posedge ref_clk) disable iff (rst)
    (!txrx && $past(!txrx)) |-> !sdo) else $error("data out not low");
  a_done_idle: assert property (@(posedge ref_clk) disable iff (rst)
    done |-> (!busy && $past(bit_count) == FRAME_BITS)) else $error("done wrong");
  a_flag_reads: assert property (@(posedge ref_clk) disable iff (rst)
    (bus_rd && sel_mode) |=> (rdata[0] == $past(busy))) else $error("flag read wrong");
  a_buf_write: assert property (@(posedge ref_clk) disable iff (rst)
    (bus_wr && sel_tx) |=> (transmit_buffer == $past(bus_wdata))) else $error("buffer");
  a_idle_no_shift: assert property (@(posedge ref_clk) disable iff (rst)
    (!busy && !start && enable) |=> $stable(shift_register)) else $error("stray shift");
endmodule : tws_channel
`default_nettype wire

// file: logic/tws_pkg.sv
// Shared constants for the three-wire serial channel
package tws_pkg;
  localparam logic [15:0] ADDR_MODE_CTRL_CH0 = 16'hff80;
  localparam logic [15:0] ADDR_MODE_CTRL_CH1 = 16'hff88;
  localparam logic [15:0] ADDR_CLOCK_CTRL_CH0 = 16'hff81;
  localparam logic [15:0] ADDR_CLOCK_CTRL_CH1 = 16'hff89;
  localparam logic [15:0] ADDR_TRANSMIT_BUFFER = 16'hff90;
  localparam logic [15:0] ADDR_SHIFT_REGISTER = 16'hff91;
  localparam logic [15:0] ADDR_STRIDE = 16'h0008;
  localparam int BIT_CHANNEL_ENABLE = 7;
  localparam int BIT_TXRX_MODE_SEL = 6;
  localparam int BIT_SLAVE_SELECT_USE = 5;
  localparam int BIT_FIRST_BIT_ORDER = 4;
  localparam int BIT_COMM_IN_PROGRESS = 0;
  localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
  localparam logic [7:0] CLOCK_CTRL_RESET = 8'h00;
  localparam logic [7:0] TRANSMIT_BUFFER_RESET = 8'h00;
  localparam logic [7:0] SHIFT_REGISTER_RESET = 8'h00;
  localparam logic [2:0] CLK_SEL_EXTERNAL = 3'h7;
  localparam logic [3:0] FRAME_BITS = 4'h8;
endpackage : tws_pkg

// file: logic/tws_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module tws_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Data
  input wire logic din,
  output logic dout
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic next_dout;

  always_comb begin
    next_stage = {stage[1:0], din};
    next_dout = (stage[2] == stage[1]) ? stage[2] : dout;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage <= 3'h0;
      dout <= 1'b0;
    end else begin
      stage <= next_stage;
      dout <= next_dout;
    end
  end
endmodule : tws_sync
`default_nettype wire

// file: logic/tws_buf2.sv
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tws_buf2 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem [2];
  logic [WIDTH-1:0] next_mem [2];
  logic rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
  logic [1:0] count, next_count;
  logic push, pop;

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_mem = mem;
    if (push) begin
      next_mem[wr_ptr] = in_data;
    end
    next_wr_ptr = push ? ~wr_ptr : wr_ptr;
    next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
    next_count = count + {1'b0, push} - {1'b0, pop};
  end

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem[0] <= '0;
      mem[1] <= '0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      mem <= next_mem;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
    end
  end
endmodule : tws_buf2
`default_nettype wire

// file: dv/tws_peer.sv
// Behavioural serial peripheral facing the channel
`timescale 1ns/1ps
`default_nettype none
module tws_peer (
  // Serial wires
  input wire logic sclk,
  input wire logic mosi,
  output logic miso
);
  logic [7:0] tx;
  logic [7:0] rx;
  bit lsb;
  int n;
  initial miso = 1'b1;
  task automatic load(input logic [7:0] b, input bit l);
    tx = b;
    lsb = l;
    n = 0;
  endtask : load
  always @(negedge sclk) begin
    if (n < 8) miso = lsb ? tx[n] : tx[7-n];
  end
  always @(posedge sclk) begin
    rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
    n = n + 1;
    // Line goes stale once hold time is over
    if (n == 8) miso <= #200 ~miso;
  end
endmodule : tws_peer
`default_nettype wire

// file: dv/tws_channel_tb.sv
// Self-checking bench for one serial channel
`timescale 1ns/1ps
`default_nettype none
module tws_channel_tb;
  import tws_pkg::*;
  localparam logic [15:0] AM = ADDR_MODE_CTRL_CH1;
  localparam logic [15:0] AC = ADDR_CLOCK_CTRL_CH1;
  localparam logic [15:0] AT = ADDR_TRANSMIT_BUFFER + ADDR_STRIDE;
  localparam logic [15:0] AS = ADDR_SHIFT_REGISTER + ADDR_STRIDE;
  logic ref_clk = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, rx_ready = 1'b1;
  logic ext_clk = 1'b1, ss_n = 1'b1, chk_low = 1'b0;
  logic sclk_o, sclk_oe, sdo, sdi, rx_valid, hit, done, h;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0] bus_wdata = 8'h00, bus_bit_mask = 8'hff, rdata, rx_data, d;
  wire logic sclk = sclk_oe ? sclk_o : ext_clk;
  int fails = 0, check_count = 0, cyc = 0, dones = 0;
  logic [7:0] rxq[$];
  always #12.5 ref_clk = ~ref_clk;
  tws_channel #(.BASE_OFFSET(ADDR_STRIDE), .HAS_SLAVE_SELECT(1'b1)) tws_channel_inst (
    .ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_bit_mask(bus_bit_mask), .bus_rdata(rdata), .bus_hit(hit),
    .serial_clock_pin_in(sclk), .serial_clock_pin_out(sclk_o), .serial_clock_pin_oe(sclk_oe),
    .serial_data_in(sdi), .serial_data_out(sdo), .slave_select_in_n(ss_n),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .transfer_done_irq(done));
  tws_peer tws_peer_inst (.sclk(sclk), .mosi(sdo), .miso(sdi));
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask : cmp1
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [15:0] a, input logic [7:0] v, input logic [7:0] m);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_bit_mask <= m;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1;
    d = rdata;
    h = hit;
  endtask : rd
  task automatic ext_frame;
    repeat (8) begin
      repeat (8) @(posedge ref_clk);
      ext_clk <= 1'b0;
      repeat (8) @(posedge ref_clk);
      ext_clk <= 1'b1;
    end
  endtask : ext_frame
  // Mode m: 0 buffer write starts, 1 shift read starts, 2 already started, external clock
  task automatic xfer(input logic [7:0] t, input logic [7:0] p, input bit l, input int m);
    int k;
    k = dones;
    tws_peer_inst.load(p, l);
    rxq.push_back(p);
    if (m == 0) wr(AT, t, 8'hff);
    if (m == 1) rd(AS);
    rd(AM);
    cmp1(d[BIT_COMM_IN_PROGRESS], 1'b1);
    if (m == 2) ext_frame();
    for (int i = 0; i < 600 && dones == k; i++) @(posedge ref_clk);
    cmp8(8'(dones - k), 8'h01);
    cmp8(tws_peer_inst.rx, m == 1 ? 8'h00 : t);
    k = dones;
    if (m == 1) begin
      tws_peer_inst.load(p, l);
      rxq.push_back(p);
    end
    rd(AS);
    cmp8(d, p);
    for (int i = 0; i < 600 && m == 1 && dones == k; i++) @(posedge ref_clk);
    rd(AM);
    cmp1(d[BIT_COMM_IN_PROGRESS], 1'b0);
  endtask : xfer
  always @(posedge ref_clk) begin
    cyc++;
    if (done === 1'b1) dones++;
    if (rx_valid && rx_ready) cmp8(rx_data, rxq.pop_front());
    if (chk_low) cmp1(sdo, 1'b0);
    if (cyc == 10000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    logic [7:0] t;
    int k;
    void'($urandom(76));
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(AM);
    cmp8(d, MODE_CTRL_RESET);
    cmp1(h, 1'b1);
    rd(AC);
    cmp8(d, CLOCK_CTRL_RESET);
    rd(AT);
    cmp8(d, TRANSMIT_BUFFER_RESET);
    rd(AS);
    cmp8(d, SHIFT_REGISTER_RESET);
    rd(ADDR_MODE_CTRL_CH0);
    cmp8(d, 8'h00);
    cmp1(h, 1'b0);
    wr(AT, 8'h5a, 8'hff);
    rd(AT);
    cmp8(d, 8'h5a);
    wr(AM, 8'hff, 8'h11);
    rd(AM);
    cmp8(d, 8'h10);
    wr(AC, 8'h03, 8'hff);
    for (int o = 0; o < 2; o++) begin
      wr(AM, o ? 8'hf0 : 8'he0, 8'hff);
      repeat (2) xfer(8'($urandom), 8'($urandom), o[0], 0);
    end
    cmp1(sclk_oe, 1'b1);
    rx_ready <= 1'b0;
    repeat (2) xfer(8'($urandom), 8'($urandom), 1'b1, 0);
    cmp1(rx_valid, 1'b1);
    rx_ready <= 1'b1;
    repeat (4) @(posedge ref_clk);
    cmp1(rx_valid, 1'b0);
    wr(AM, 8'h80, 8'hff);
    repeat (2) @(posedge ref_clk);
    chk_low <= 1'b1;
    xfer(8'h00, 8'($urandom), 1'b0, 1);
    chk_low <= 1'b0;
    wr(AM, 8'hc0, 8'hff);
    tws_peer_inst.load(8'h00, 1'b0);
    wr(AT, 8'($urandom), 8'hff);
    repeat (40) @(posedge ref_clk);
    wr(AM, 8'h00, 8'h80);
    k = dones;
    rd(AM);
    cmp8(d, 8'h40);
    rd(AS);
    cmp8(d, 8'h00);
    repeat (300) @(posedge ref_clk);
    cmp8(8'(dones - k), 8'h00);
    wr(AC, {5'h00, CLK_SEL_EXTERNAL}, 8'hff);
    wr(AM, 8'he0, 8'hff);
    t = 8'($urandom);
    k = dones;
    wr(AT, t, 8'hff);
    ext_frame();
    rd(AM);
    cmp1(d[BIT_COMM_IN_PROGRESS], 1'b1);
    cmp8(8'(dones - k), 8'h00);
    cmp1(sclk_oe, 1'b0);
    ss_n <= 1'b0;
    xfer(t, 8'($urandom), 1'b0, 2);
    tally_and_finish();
  end
endmodule : tws_channel_tb
`default_nettype wire
